// ==== logic/rof_relay_select.sv ====
// Relay output function selector with APB registers and interrupt.
// Assumes one clock, synchronous inputs, an APB master on the same clock.
`timescale 1ns/1ps
`include "rof_defines.svh"
`default_nettype none

module rof_relay_select
  import rof_pkg::*;
#(
  parameter int RUN_W = 32
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire rof_cond_s cond_in,
  input wire logic [RUN_W-1:0] accumulated_run_time_counter_in,
  output logic relay_out,
  output logic irq_out
);

  // Elaboration check on counter width
  if (RUN_W < 1 || RUN_W > 32) begin : g_chk
    $error("RUN_W must be 1 to 32");
  end

  logic [4:0] sel_reg;
  logic [RUN_W-1:0] run_cutoff_time_setting_reg;
  logic [`ROF_NUM_EVT-1:0] irq_stat_reg;
  logic [`ROF_NUM_EVT-1:0] irq_mask_reg;
  logic [`ROF_NUM_EVT-1:0] evt_now;
  logic [`ROF_NUM_EVT-1:0] evt_prev_reg;
  logic relay_next;
  logic cutoff_hit;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic [31:0] rdata_next;

  assign wr_acc = psel_in && penable_in && pwrite_in && clk_en_in;
  assign rd_acc = psel_in && penable_in && !pwrite_in && clk_en_in;
  assign cutoff_hit = accumulated_run_time_counter_in >= run_cutoff_time_setting_reg;

  // Indication chosen by the stored selection code
  always_comb begin
    relay_next = 1'b0;
    unique case (sel_reg)
      `ROF_CODE_READY: relay_next = !cond_in.fault && cond_in.bus_ok && !cond_in.run_inhibit;
      `ROF_CODE_FAULT: relay_next = cond_in.fault;
      `ROF_CODE_CUTOFF: relay_next = cutoff_hit;
      `ROF_CODE_FWD: relay_next = cond_in.run_fwd;
      `ROF_CODE_REV: relay_next = cond_in.run_rev;
      `ROF_CODE_SLEEP: relay_next = cond_in.water_app && cond_in.sleep;
      `ROF_CODE_OVERP: relay_next = cond_in.water_app && cond_in.overpressure;
      `ROF_CODE_UNDERP: relay_next = cond_in.water_app && cond_in.underpressure;
      `ROF_CODE_PIPE_DRY: relay_next = cond_in.water_app && cond_in.pipe_dry;
      `ROF_CODE_TANK_DRY: relay_next = cond_in.water_app && cond_in.tank_dry;
      `ROF_CODE_BURST: relay_next = cond_in.water_app && cond_in.pipe_burst;
      default: relay_next = 1'b0;
    endcase
  end

  // Relay register follows indication each cycle that clock enable is high
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      relay_out <= 1'b0;
    end else if (clk_en_in) begin
      relay_out <= relay_next;
    end
  end

  // Software written configuration
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sel_reg <= `ROF_SEL_RST;
      run_cutoff_time_setting_reg <= RUN_W'(`ROF_CUTOFF_RST);
      irq_mask_reg <= '0;
    end else if (wr_acc) begin
      if (paddr_in == `ROF_SEL_OFS) begin
        sel_reg <= pwdata_in[4:0];
      end
      if (paddr_in == `ROF_CUTOFF_OFS) begin
        run_cutoff_time_setting_reg <= pwdata_in[RUN_W-1:0];
      end
      if (paddr_in == `ROF_IRQ_MASK_OFS) begin
        irq_mask_reg <= pwdata_in[`ROF_NUM_EVT-1:0];
      end
    end
  end

  // Rising edges of relay, cutoff and fault are events
  assign evt_now = {cond_in.fault, cutoff_hit, relay_next};

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      evt_prev_reg <= '0;
    end else if (clk_en_in) begin
      evt_prev_reg <= evt_now;
    end
  end

  // Sticky status, cleared by read; a new event wins over the clear
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_stat_reg <= '0;
    end else if (clk_en_in) begin
      if (rd_acc && paddr_in == `ROF_IRQ_STAT_OFS) begin
        irq_stat_reg <= evt_now & ~evt_prev_reg;
      end else begin
        irq_stat_reg <= irq_stat_reg | (evt_now & ~evt_prev_reg);
      end
    end
  end

  // Interrupt level from masked status
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read data multiplexer and address decode
  always_comb begin
    rdata_next = 32'h00000000;
    addr_ok = 1'b1;
    unique case (paddr_in)
      `ROF_SEL_OFS: rdata_next[4:0] = sel_reg;
      `ROF_CUTOFF_OFS: rdata_next[RUN_W-1:0] = run_cutoff_time_setting_reg;
      `ROF_STATUS_OFS: rdata_next[`ROF_NUM_EVT-1:0] = evt_prev_reg;
      `ROF_IRQ_STAT_OFS: rdata_next[`ROF_NUM_EVT-1:0] = irq_stat_reg;
      `ROF_IRQ_MASK_OFS: rdata_next[`ROF_NUM_EVT-1:0] = irq_mask_reg;
      `ROF_RUNTIME_OFS: rdata_next[RUN_W-1:0] = accumulated_run_time_counter_in;
      default: addr_ok = 1'b0;
    endcase
  end

  // APB answer: no wait state, pready registered from setup
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end else if (clk_en_in) begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !addr_ok;
      prdata_out <= (psel_in && !penable_in && !pwrite_in) ? rdata_next : 32'h00000000;
    end
  end

endmodule // rof_relay_select

`default_nettype wire

// ==== logic/rof_defines.svh ====
// Constants for the relay output function selector.
// Assumes inclusion by bare name from the logic folder.
`ifndef ROF_DEFINES_SVH
`define ROF_DEFINES_SVH
// Register byte offsets
`define ROF_SEL_OFS 12'h000
`define ROF_CUTOFF_OFS 12'h004
`define ROF_STATUS_OFS 12'h008
`define ROF_IRQ_STAT_OFS 12'h00c
`define ROF_IRQ_MASK_OFS 12'h010
`define ROF_RUNTIME_OFS 12'h014
// Reset values
`define ROF_SEL_RST 5'h11
`define ROF_CUTOFF_RST 32'hffffffff
// Selection codes
`define ROF_CODE_READY 5'h10
`define ROF_CODE_FAULT 5'h11
`define ROF_CODE_CUTOFF 5'h13
`define ROF_CODE_FWD 5'h14
`define ROF_CODE_REV 5'h15
`define ROF_CODE_SLEEP 5'h17
`define ROF_CODE_OVERP 5'h18
`define ROF_CODE_UNDERP 5'h19
`define ROF_CODE_PIPE_DRY 5'h1a
`define ROF_CODE_TANK_DRY 5'h1b
`define ROF_CODE_BURST 5'h1c
// Status and interrupt bit positions
`define ROF_BIT_RELAY 0
`define ROF_BIT_CUTOFF 1
`define ROF_BIT_FAULT 2
`define ROF_NUM_EVT 3
`endif

// ==== logic/rof_pkg.sv ====
// Types for the relay output function selector.
// Assumes rof_defines.svh supplies the constants.
`default_nettype none
package rof_pkg;
  // Drive conditions feeding the selector
  typedef struct packed {
    logic fault;
    logic bus_ok;
    logic run_inhibit;
    logic run_fwd;
    logic run_rev;
    logic water_app;
    logic sleep;
    logic overpressure;
    logic underpressure;
    logic pipe_dry;
    logic tank_dry;
    logic pipe_burst;
  } rof_cond_s;
endpackage
`default_nettype wire

// ==== testbench/rof_contact.sv ====
// Relay contact and wiring at the far side.
// Assumes the coil level comes from the selector.
`timescale 1ns/1ps
`default_nettype none
module rof_contact (
  input wire logic coil_in,
  output logic closed_out
);
  // Contact closes with the coil
  assign closed_out = coil_in;
endmodule // rof_contact
`default_nettype wire

// ==== testbench/rof_props.sv ====
// Checker for the relay selector ports.
// Assumes checks pause while clock enable is low.
`timescale 1ns/1ps
`default_nettype none
module rof_props
  import rof_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic clk_en_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic pready_out,
  input wire rof_cond_s cond_in,
  input wire logic relay_out
);
  logic [4:0] sel_reg;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in || !clk_en_in);
  // Shadow of the stored selection
  always_ff @(posedge mclk_in) begin
    if (rst_in) sel_reg <= 5'h11;
    else if (psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000) sel_reg <= pwdata_in[4:0];
  end
  ready_late_a: assert property (psel_in && !penable_in |=> pready_out) else $error("late");
  ready_pulse_a: assert property (pready_out |=> !pready_out) else $error("long");
  fault_sel_a: assert property (sel_reg == 5'h11 |=> relay_out == $past(cond_in.fault)) else $error("fault");
  fwd_sel_a: assert property (sel_reg == 5'h14 |=> relay_out == $past(cond_in.run_fwd)) else $error("fwd");
  rev_sel_a: assert property (sel_reg == 5'h15 |=> relay_out == $past(cond_in.run_rev)) else $error("rev");
  ready_sel_a: assert property (sel_reg == 5'h10 |=> relay_out ==
    $past(cond_in.bus_ok && !cond_in.fault && !cond_in.run_inhibit)) else $error("ready");
  reserved_off_a: assert property (sel_reg == 5'h12 || sel_reg == 5'h16 |=> !relay_out) else $error("rsv");
  water_gate_a: assert property (sel_reg > 5'h16 && !cond_in.water_app |=> !relay_out) else $error("water");
endmodule // rof_props
bind rof_relay_select rof_props i_props (.*);
`default_nettype wire

// ==== testbench/rof_relay_select_tb.sv ====
// Bench for the relay selector: table, cutoff, refusal, interrupt, reset.
// Assumes clock enable held high except during the freeze check.
`timescale 1ns/1ps
`default_nettype none
module rof_relay_select_tb
  import rof_pkg::*;
;
  logic mclk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic pready_out, pslverr_out, relay_out, irq_out, contact, err;
  logic ce = 1;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, rd, rt = 4;
  rof_cond_s cond_in = '0;
  int n_fail = 0, checked = 0, cyc = 0;
  logic [17:0] rows [16] = '{18'h20801, 18'h20c00, 18'h23001, 18'h25ffe, 18'h26000, 18'h28201, 18'h2a101,
    18'h2dffe, 18'h2e0c1, 18'h2e040, 18'h300a1, 18'h32091, 18'h34089, 18'h36085, 18'h38083, 18'h38002};
  always #4 mclk_in = ~mclk_in;
  rof_relay_select i_dut (.mclk_in, .rst_in, .clk_en_in(ce), .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .cond_in, .accumulated_run_time_counter_in(rt),
    .relay_out, .irq_out);
  rof_contact i_relay (.coil_in(relay_out), .closed_out(contact));
  // One APB transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in) {psel_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, w, a, d};
    @(posedge mclk_in) penable_in <= 1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask
  task automatic chk(input string s, input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic conclude;
    $display("failed %0d of %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk_in) if (++cyc == 3000) begin
    n_fail++;
    conclude();
  end
  initial begin
    repeat (2) @(posedge mclk_in);
    rst_in <= 0;
    // Table of codes and conditions
    foreach (rows[i]) begin
      apb(1, 12'h000, 32'(rows[i][17:13]));
      @(posedge mclk_in) cond_in <= rof_cond_s'(rows[i][12:1]);
      @(posedge mclk_in) #1 chk("relay", 32'(contact), 32'(rows[i][0]));
    end
    // Cutoff one below and at the setting
    apb(1, 12'h004, 32'h5);
    apb(1, 12'h000, 32'h13);
    @(posedge mclk_in) #1 chk("relay", 32'(contact), 0);
    @(posedge mclk_in) rt <= 5;
    @(posedge mclk_in) #1 chk("relay", 32'(contact), 1);
    // Unmapped read refused
    apb(0, 12'h020, 0);
    chk("err", 32'(err), 1);
    chk("rdata", rd, 0);
    // Masked, then unmasked, then cleared interrupt
    apb(0, 12'h00c, 0);
    apb(1, 12'h000, 32'h11);
    cond_in.fault <= 1;
    repeat (4) @(posedge mclk_in);
    chk("irq", 32'(irq_out), 0);
    apb(1, 12'h010, 32'h4);
    repeat (2) @(posedge mclk_in);
    chk("irq", 32'(irq_out), 1);
    apb(0, 12'h00c, 0);
    chk("stat", rd, 32'h4);
    repeat (2) @(posedge mclk_in);
    chk("irq", 32'(irq_out), 0);
    // Clock enable low freezes the relay
    ce <= 0;
    cond_in.fault <= 0;
    repeat (3) @(posedge mclk_in);
    #1 chk("frozen", 32'(contact), 1);
    @(posedge mclk_in) ce <= 1;
    @(posedge mclk_in) #1 chk("relay", 32'(contact), 0);
    cond_in.fault <= 1;
    // Reset mid-run restores fault selection
    @(posedge mclk_in) rst_in <= 1;
    @(posedge mclk_in) #1 chk("relay", 32'(contact), 0);
    @(posedge mclk_in) rst_in <= 0;
    @(posedge mclk_in) #1 chk("relay", 32'(contact), 1);
    apb(0, 12'h010, 0);
    chk("mask", rd, 0);
    conclude();
  end
endmodule // rof_relay_select_tb
`default_nettype wire
